// *** rtl/usm_pkg.sv ***
// Behaviour
// [R1] With the receiver enabled, the serial input pin is taken over as the master-in line.
// [R2] Clearing the receiver enable flushes every unread byte in the receive buffer.
// [R3] Software must enable the transmitter for any transfer, since only it drives the shift clock.
// [R4] With the transmitter enabled, the serial output pin is driven as the master-out line.
// [R5] After the transmitter enable clears, shifting goes on until shifter and buffer are empty, then the pin is released.
// [R6] Software writes zeros to bits 2:0 of the enables register; they read back fixed.
// [R7] Mode field 7:6 selects async, sync, reserved or master SPI; only 11 runs master SPI. A drain after a disable launches under any code.
// [R8] Bit order, phase and polarity written with the mode select apply to the following transfers.
// [R9] Software writes zeros to bits 5:3 of the mode register; they read back as zero.
// [R10] Bit order one sends the least significant bit first, zero the most significant.
// [R11] Clock phase picks sampling on the leading or the trailing shift clock edge.
// [R12] Clock polarity sets the idle level of the shift clock.
// [R13] A data write starts a transfer; the byte moves to the shifter when it is free.
// [R14] Transmit complete sets when a frame ends with the buffer empty; cleared by writing one.
// [R15] Transmit buffer empty is one after reset and whenever the buffer may be written.
// [R16] Frame error, overrun and parity flags always read zero.
// [R17] Shift clock rate comes from the baud divider, eight bits per frame, clock only during a frame.
package usm_pkg;
  localparam logic [2:0] ADDR_DATA    = 3'h0;
  localparam logic [2:0] ADDR_STATUS  = 3'h1;
  localparam logic [2:0] ADDR_ENABLES = 3'h2;
  localparam logic [2:0] ADDR_MODE    = 3'h3;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h5;
  localparam logic [2:0] ADDR_IMASK   = 3'h6;

  localparam int ST_RXC   = 7;
  localparam int ST_TXC   = 6;
  localparam int ST_UDRE  = 5;
  localparam int EN_RXEN  = 4;
  localparam int EN_TXEN  = 3;
  localparam int MD_SEL_H = 7;
  localparam int MD_SEL_L = 6;
  localparam int MD_ORDER = 2;
  localparam int MD_PHASE = 1;
  localparam int MD_POL   = 0;

  localparam logic [7:0] ENABLES_RST = 8'h06;
  localparam logic [7:0] ENABLES_RO  = 8'h07;
  localparam logic [7:0] MODE_RST    = 8'h06;
  localparam logic [7:0] MODE_WMASK  = 8'hc7;
  localparam logic [1:0] MODE_MSPI   = 2'h3;
  localparam logic [7:0] IMASK_WMASK = 8'he0;
  localparam int BITS_PER_FRAME      = 8;
  localparam int RX_DEPTH            = 2;
endpackage

// *** rtl/usm_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module usm_sync
  import usm_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic d,
  output var  logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } usm_sync_t;
  usm_sync_t st_r, st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule
`default_nettype wire

// *** rtl/usm_rxbuf.sv ***
`timescale 1ns/1ps
`default_nettype none
module usm_rxbuf
  import usm_pkg::*;
#(
  parameter int DEPTH = RX_DEPTH
)
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       flush,
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  input  wire logic       pop,
  output var  logic [7:0] head,
  output var  logic       not_empty
);
  // Full buffer drops the newest byte, keeping the oldest
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [1:0]            cnt;
  } usm_rxbuf_t;
  usm_rxbuf_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (flush) begin
      st_nxt.cnt = 2'h0; // [R2]
    end else begin
      if (pop && st_r.cnt != 2'h0) begin
        st_nxt.mem[0] = st_r.mem[1];
        st_nxt.cnt    = st_r.cnt - 2'h1;
      end
      if (push && st_nxt.cnt < 2'(DEPTH)) begin
        st_nxt.mem[st_nxt.cnt[0]] = push_data;
        st_nxt.cnt = st_nxt.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign head      = st_r.mem[0];
  assign not_empty = st_r.cnt != 2'h0;
endmodule
`default_nettype wire

// *** rtl/usm_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module usm_top
  import usm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  input  wire logic       serial_in_pin,
  output var  logic       serial_out_pin,
  output var  logic       serial_out_pin_oen,
  output var  logic       shift_clock_pin,
  output var  logic       shift_clock_pin_oen,
  output var  logic       serial_in_pin_owned,
  output var  logic       irq
);
  typedef enum logic [1:0] {IDLE, LEAD, TRAIL} usm_state_t;

  typedef struct packed {
    usm_state_t  state;
    logic [7:0]  enables;
    logic [7:0]  mode;
    logic [11:0] baud;
    logic [7:0]  imask;
    logic [7:0]  txbuf;
    logic        txbuf_full;
    logic [7:0]  shift;
    logic [7:0]  rxshift;
    logic [2:0]  bitcnt;
    logic [11:0] divcnt;
    logic        txc;
    logic        tx_active;
    logic        sck;
    logic        mosi;
    logic [7:0]  rdata;
    logic        irq;
    logic        frame_order;
    logic        frame_phase;
    logic        frame_pol;
  } usm_top_t;
  usm_top_t st_r, st_nxt;

  logic       miso;
  logic [7:0] rx_head;
  logic       rx_ne;
  logic       rx_push;
  logic       rx_pop;
  logic       rx_flush;
  logic [7:0] rx_word;
  logic       mspi;
  logic [7:0] status;

  usm_sync u_sync (
    .clock  (clock),
    .resetn (resetn),
    .d      (serial_in_pin),
    .q      (miso)
  );

  usm_rxbuf #(.DEPTH(RX_DEPTH)) u_rxbuf (
    .clock     (clock),
    .resetn    (resetn),
    .flush     (rx_flush),
    .push      (rx_push),
    .push_data (rx_word),
    .pop       (rx_pop),
    .head      (rx_head),
    .not_empty (rx_ne)
  );

  // Only the master SPI code starts a frame while enabled; a drain after a disable launches under any code
  assign mspi = st_r.mode[MD_SEL_H:MD_SEL_L] == MODE_MSPI; // [R7]

  // Receiver error flags have no use in this mode
  always_comb begin
    status           = 8'h00; // [R16]
    status[ST_RXC]   = rx_ne;
    status[ST_TXC]   = st_r.txc;
    status[ST_UDRE]  = !st_r.txbuf_full; // [R15]
  end

  assign rx_pop   = rd && addr == ADDR_DATA;
  // Flush acts on the write itself, so no stale byte survives a disable
  assign rx_flush = wr && addr == ADDR_ENABLES && !wdata[EN_RXEN]; // [R2]

  always_comb begin
    logic       tick;
    logic       sample;
    logic       txen_eff;
    logic [7:0] rxn;
    logic       advance;
    logic       launch;
    logic       frame_end;
    tick     = 1'b0;
    advance  = 1'b0;
    launch   = 1'b0;
    frame_end = 1'b0;
    sample   = 1'b0;
    txen_eff = 1'b0;
    rxn      = 8'h00;
    st_nxt   = st_r;
    rx_push  = 1'b0;
    rx_word  = 8'h00;

    // Register writes
    if (wr) begin
      case (addr)
        ADDR_DATA: begin
          if (!st_r.txbuf_full) begin
            st_nxt.txbuf      = wdata; // [R13]
            st_nxt.txbuf_full = 1'b1;
          end
        end

        ADDR_STATUS: begin
          if (wdata[ST_TXC]) begin
            st_nxt.txc = 1'b0; // [R14]
          end
        end

        ADDR_ENABLES: begin
          // Fixed low bits: a stray one written by software cannot stick
          st_nxt.enables = (wdata & ~ENABLES_RO) | (ENABLES_RST & ENABLES_RO); // [R6]
        end

        ADDR_MODE: begin
          st_nxt.mode = wdata & MODE_WMASK; // [R8] [R9]
        end

        ADDR_BAUD_LO: begin
          st_nxt.baud[7:0] = wdata; // [R17]
        end

        ADDR_BAUD_HI: begin
          st_nxt.baud[11:8] = wdata[3:0]; // [R17]
        end

        ADDR_IMASK: begin
          st_nxt.imask = wdata & IMASK_WMASK;
        end

        default: begin
        end
      endcase
    end

    // Divider: one half bit every baud+1 cycles
    if (st_r.state != IDLE) begin // [R17]
      if (st_r.divcnt == 12'h000) begin
        tick          = 1'b1;
        st_nxt.divcnt = st_r.baud;
      end else begin
        st_nxt.divcnt = st_r.divcnt - 12'h001;
      end
    end

    // Transmitter runs while enabled or work remains
    txen_eff = st_r.enables[EN_TXEN] && mspi; // [R3]
    // Drain runs until buffer and shifter are empty, so a write made during it is sent too; later writes wait for an enable
    st_nxt.tx_active = st_r.enables[EN_TXEN]
                     || (st_r.tx_active && (st_r.txbuf_full || st_r.state != IDLE)); // [R5]
    launch = st_r.txbuf_full && st_r.tx_active
           && (txen_eff || !st_r.enables[EN_TXEN]); // [R3] [R5]

    case (st_r.state)
      IDLE: begin
        st_nxt.sck = st_r.frame_pol; // [R12]
        if (launch) begin
          st_nxt.shift       = st_r.txbuf; // [R13]
          // A data write in this cycle saw a full buffer and was refused
          st_nxt.txbuf_full  = 1'b0; // [R15]
          st_nxt.frame_order = st_r.mode[MD_ORDER]; // [R8]
          st_nxt.frame_phase = st_r.mode[MD_PHASE];
          st_nxt.frame_pol   = st_r.mode[MD_POL];
          st_nxt.sck         = st_r.mode[MD_POL];
          st_nxt.bitcnt      = 3'h0;
          st_nxt.divcnt      = st_r.baud;
          st_nxt.state       = LEAD;
          if (!st_r.mode[MD_PHASE]) begin
            st_nxt.mosi = st_r.mode[MD_ORDER] ? st_r.txbuf[0] : st_r.txbuf[7]; // [R10]
          end
        end
      end
      LEAD: begin
        if (tick) begin
          st_nxt.sck   = !st_r.frame_pol; // [R12]
          st_nxt.state = TRAIL;
          if (!st_r.frame_phase) begin
            sample = 1'b1; // [R11]
          end else begin
            // Phase one launches each bit on the leading edge
            st_nxt.mosi = st_r.frame_order ? st_r.shift[0] : st_r.shift[7]; // [R10]
          end
        end
      end
      TRAIL: begin
        if (tick) begin
          st_nxt.sck = st_r.frame_pol;
          advance    = 1'b1;
          if (st_r.frame_phase) begin
            sample = 1'b1; // [R11]
          end
          if (st_r.bitcnt == 3'(BITS_PER_FRAME - 1)) begin
            st_nxt.state = IDLE;
          end else begin
            st_nxt.bitcnt = st_r.bitcnt + 3'h1;
            st_nxt.state  = LEAD;
          end
        end
      end
      default: st_nxt.state = IDLE;
    endcase

    if (sample) begin
      rxn = st_r.frame_order ? {miso, st_r.rxshift[7:1]} : {st_r.rxshift[6:0], miso}; // [R10]
      st_nxt.rxshift = rxn;
    end

    // Shift on the trailing edge, and relaunch there in phase zero, so data never moves on the sampling edge
    if (advance) begin
      st_nxt.shift = st_r.frame_order ? {1'b0, st_r.shift[7:1]} : {st_r.shift[6:0], 1'b0};
      if (!st_r.frame_phase && st_r.bitcnt != 3'(BITS_PER_FRAME - 1)) begin
        st_nxt.mosi = st_r.frame_order ? st_r.shift[1] : st_r.shift[6]; // [R10] [R11]
      end
    end

    // End of frame
    frame_end = st_r.state == TRAIL && tick
              && st_r.bitcnt == 3'(BITS_PER_FRAME - 1); // [R17]
    if (frame_end) begin
      if (st_r.enables[EN_RXEN]) begin
        rx_push = 1'b1; // [R1]
        rx_word = st_nxt.rxshift;
      end
      if (!st_r.txbuf_full) begin
        st_nxt.txc = 1'b1; // [R14]
      end
    end

    // Read data valid the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (rd) begin
      case (addr)
        ADDR_DATA: begin
          st_nxt.rdata = rx_head; // [R13]
        end

        ADDR_STATUS: begin
          st_nxt.rdata = status; // [R16]
        end

        ADDR_ENABLES: begin
          st_nxt.rdata = st_r.enables; // [R6]
        end

        ADDR_MODE: begin
          st_nxt.rdata = st_r.mode; // [R9]
        end

        ADDR_BAUD_LO: begin
          st_nxt.rdata = st_r.baud[7:0];
        end

        ADDR_BAUD_HI: begin
          st_nxt.rdata = {4'h0, st_r.baud[11:8]};
        end

        ADDR_IMASK: begin
          st_nxt.rdata = st_r.imask;
        end

        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end

    st_nxt.irq = |(status & st_r.imask);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r           <= '0;
      st_r.state     <= IDLE;
      st_r.enables   <= ENABLES_RST;
      st_r.mode      <= MODE_RST;
      st_r.frame_order <= MODE_RST[MD_ORDER];
      st_r.frame_phase <= MODE_RST[MD_PHASE];
      st_r.frame_pol   <= MODE_RST[MD_POL];
      st_r.sck       <= MODE_RST[MD_POL];
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin ownership follows registered enables; tx pin held until drained
  assign rdata               = st_r.rdata;
  assign serial_out_pin      = st_r.mosi;
  assign serial_out_pin_oen  = !st_r.tx_active; // [R4] [R5]
  assign shift_clock_pin     = st_r.sck;
  assign shift_clock_pin_oen = !st_r.tx_active;
  assign serial_in_pin_owned = st_r.enables[EN_RXEN]; // [R1]
  assign irq                 = st_r.irq;
endmodule
`default_nettype wire

// *** dv/usm_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module usm_top_monitor
  import usm_pkg::*;
(
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       serial_out_pin_oen,
  input wire logic       shift_clock_pin_oen,
  input wire logic       serial_in_pin_owned
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Two edges allowed: control register, then tx_active for the tx pin; rx ownership follows the register after one
  a_rx_pin_take: assert property (
    wr && addr == ADDR_ENABLES && wdata[EN_RXEN] |-> ##[1:2] serial_in_pin_owned)
    else $error("rx pin not taken");
  a_rx_pin_free: assert property (
    wr && addr == ADDR_ENABLES && !wdata[EN_RXEN] |-> ##[1:2] !serial_in_pin_owned)
    else $error("rx pin not freed");
  a_tx_pin_take: assert property (
    wr && addr == ADDR_ENABLES && wdata[EN_TXEN] |-> ##[1:2] !serial_out_pin_oen)
    else $error("tx pin not driven");
  a_oen_pair_same: assert property (serial_out_pin_oen == shift_clock_pin_oen)
    else $error("oen pair split");
  a_status_low_zero: assert property (rd && addr == ADDR_STATUS |=> rdata[4:0] == 5'h00)
    else $error("status low bits");
  a_mode_resv_zero: assert property (rd && addr == ADDR_MODE |=> rdata[5:3] == 3'h0)
    else $error("mode reserved bits");
  a_enable_resv_fix: assert property (rd && addr == ADDR_ENABLES |=> rdata[2:0] == 3'h6)
    else $error("enables reserved bits");
  a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata not idle");
endmodule
bind usm_top usm_top_monitor u_mon (.clock, .resetn, .addr, .wdata, .wr, .rd, .rdata,
  .serial_out_pin_oen, .shift_clock_pin_oen, .serial_in_pin_owned);
`default_nettype wire

// *** dv/usm_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module usm_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] seed_byte,
  output wire logic       miso,
  output var  logic [7:0] rx_byte,
  output var  int         frames
);
  int         k = 0;
  int         n = 0;
  logic       late = 1'b0;
  logic [7:0] sh = 8'h00;
  wire  [7:0] cur = seed_byte ^ frames[7:0];
  wire        bit_k = lsb ? cur[k[2:0]] : cur[3'h7 - k[2:0]];
  assign miso = cpha ? late : bit_k;
  initial frames = 0;
  always @(sck) begin
    // Idle-level step with no frame open is a polarity change
    if (sck == cpol && n == 0 && k == 0) begin
    end else if (sck == (cpol ~^ cpha)) begin
      sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      n = (n + 1) % 8;
      if (n == 0) begin
        rx_byte = sh;
        frames = frames + 1;
        late <= #60 ~late;
      end
    end else begin
      if (cpha) late = bit_k;
      k = (k + 1) % 8;
    end
  end
endmodule
`default_nettype wire

// *** dv/usm_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module usm_tb_top;
  import usm_pkg::*;
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       cpol = 1'b0, cpha = 1'b0, lsb = 1'b0;
  logic       miso, mosi, mosi_oen, sck, owned, irq;
  logic [7:0] rdata, rx_byte, d, v, seed_byte = 8'h00;
  logic [7:0] q_tx[$], q_rx[$];
  logic [2:0] ra[4] = '{3'h1, 3'h2, 3'h3, 3'h7};
  logic [7:0] re[4] = '{8'h20, 8'h06, 8'h06, 8'h00};
  int         frames, nf = 0, errors = 0, checks = 0, seed = 94085;
  always #10 clock = ~clock;
  usm_top dut (.clock, .resetn, .addr, .wdata, .wr, .rd, .rdata, .serial_in_pin(miso),
    .serial_out_pin(mosi), .serial_out_pin_oen(mosi_oen), .shift_clock_pin(sck),
    .shift_clock_pin_oen(), .serial_in_pin_owned(owned), .irq);
  usm_slave_model u_slave (.sck, .mosi, .cpol, .cpha, .lsb, .seed_byte, .miso, .rx_byte,
    .frames);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] x);
    @(posedge clock);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [7:0] x);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    x = rdata;
  endtask
  task automatic send;
    d = 8'($random(seed));
    wreg(ADDR_DATA, d);
    q_tx.push_back(d);
    q_rx.push_back(seed_byte ^ nf[7:0]);
    nf++;
  endtask
  task automatic wait_txc(input logic [7:0] ei);
    int i;
    v = 8'h00;
    for (i = 0; i < 300 && v[ST_TXC] !== 1'b1; i++) rreg(ADDR_STATUS, v);
    chk(v & 8'h60, 8'h60);
    chk({7'h00, irq}, ei);
    chk(rx_byte, q_tx[$]);
    chk(frames[7:0], nf[7:0]);
    chk({7'h00, sck}, {7'h00, cpol});
    q_tx.delete();
    wreg(ADDR_STATUS, 8'h40);
  endtask
  task automatic rdrx;
    rreg(ADDR_DATA, v);
    chk(v, q_rx.pop_front());
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    foreach (ra[i]) begin
      rreg(ra[i], v);
      chk(v, re[i]);
    end
    $display("reset test done");
    // Half bit of four clocks keeps the two-flop input sync well inside a bit
    wreg(ADDR_BAUD_LO, 8'h03);
    wreg(ADDR_IMASK, 8'h40);
    for (int f = 0; f < 8; f++) begin
      {cpol, cpha, lsb} = f[2:0];
      seed_byte = 8'($random(seed));
      wreg(ADDR_MODE, {MODE_MSPI, 3'h0, lsb, cpha, cpol});
      wreg(ADDR_ENABLES, 8'h18);
      send();
      wait_txc(8'h01);
      rdrx();
      chk({7'h00, irq}, 8'h00);
    end
    $display("format test done");
    send();
    repeat (3) @(posedge clock);
    rreg(ADDR_STATUS, v);
    chk(v & 8'h20, 8'h20);
    send();
    wreg(ADDR_ENABLES, 8'h10);
    rreg(ADDR_STATUS, v);
    chk(v & 8'h20, 8'h00);
    wreg(ADDR_IMASK, 8'h00);
    wait_txc(8'h00);
    chk({7'h00, mosi_oen}, 8'h01);
    wreg(ADDR_ENABLES, 8'h00);
    rreg(ADDR_STATUS, v);
    chk(v & 8'h80, 8'h00);
    chk({7'h00, owned}, 8'h00);
    q_rx.delete();
    $display("drain test done");
    wreg(ADDR_ENABLES, 8'h10);
    send();
    for (int m = 0; m < 4; m++) begin
      repeat (200) @(posedge clock);
      chk(frames[7:0], 8'(nf - 1));
      wreg(ADDR_MODE, {m[1:0], 3'h0, lsb, cpha, cpol});
      wreg(ADDR_ENABLES, 8'h18);
    end
    wait_txc(8'h00);
    rdrx();
    $display("mode test done");
    complete_run();
  end
endmodule
`default_nettype wire
